/* include/lrwpsc_map.svh */
// Purpose: Register map, field positions, reset values and timing counts
//          for the reset, wake-up and power-state controller.
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register port.
// Notes:   Byte addresses; config space starts at LRWPSC_CFG_BASE.
`ifndef LRWPSC_MAP_SVH
`define LRWPSC_MAP_SVH

`define LRWPSC_ADR_BMCW 8'h00
`define LRWPSC_ADR_RCW 8'h04
`define LRWPSC_ADR_PSW 8'h08
`define LRWPSC_ADR_XCVR 8'h0C
`define LRWPSC_ADR_IRQ_STAT 8'h10
`define LRWPSC_ADR_IRQ_MASK 8'h14
`define LRWPSC_ADR_PMCSR 8'h40
`define LRWPSC_CFG_BASE 8'h40

`define LRWPSC_BIT_SWRST 0
`define LRWPSC_BIT_WOL 18
`define LRWPSC_BIT_PME_STAT 15
`define LRWPSC_BIT_XCVR_RST 15

`define LRWPSC_IRQ_WAKE 0
`define LRWPSC_IRQ_XCVR_DONE 1
`define LRWPSC_IRQ_PM_CHANGE 2
`define LRWPSC_IRQ_W 3

`define LRWPSC_RCW_HI_RST 16'h0000
`define LRWPSC_XCVR_CTRL_RST 15'h0000
`define LRWPSC_IRQ_RST 3'h0

`define LRWPSC_WAKE_SYNC_LEN 6
`define LRWPSC_WAKE_ADDR_REPS 16
`define LRWPSC_ADDR_BYTES 6

`define LRWPSC_CLK_PERIOD_NS 25
`define LRWPSC_XCVR_RST_NS 1000
`define LRWPSC_XCVR_RST_CYC \
	((`LRWPSC_XCVR_RST_NS + `LRWPSC_CLK_PERIOD_NS - 1) / `LRWPSC_CLK_PERIOD_NS)

`endif

/* include/lrwpsc_pkg.sv */
// Purpose: Types shared by the reset, wake-up and power-state controller.
// Assumes: Nothing beyond the map header.
// Notes:   Receive beats come from the MAC receive path on the same clock.
`default_nettype none
package lrwpsc_pkg;
	typedef enum logic [1:0] {
		LRWPSC_D0 = 2'b00,
		LRWPSC_D1 = 2'b01,
		LRWPSC_D2 = 2'b10,
		LRWPSC_D3 = 2'b11
	} lrwpsc_pm_state_t;

	// One received byte; addr_ok and fcs_ok only count with eof
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic addr_ok;
		logic fcs_ok;
		logic [7:0] data;
	} lrwpsc_rx_beat_t;
endpackage
`default_nettype wire

/* src/lrwpsc_wake_detect.sv */
// Purpose: Finds a wake pattern in a received frame and pulses at frame end.
// Assumes: Beats on clk_sys_in; station address byte 0 is sent first.
// Notes:   An address whose first byte is 0xFF is not recognised.
`default_nettype none
`include "lrwpsc_map.svh"
module lrwpsc_wake_detect import lrwpsc_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic clr_in,
	input wire logic enable_in,
	input wire lrwpsc_rx_beat_t beat_in,
	input wire logic [47:0] station_addr_in,
	output logic wake_out
);
	logic [2:0] ff_reg, ff_next;
	logic [2:0] sel_reg, sel_next;
	logic [3:0] rep_reg, rep_next;
	logic match_reg, match_next;
	logic hit_reg, hit_next;
	logic wake_reg, wake_next;

	function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
		addr_byte = a[8'(47 - 8 * i) -: 8];
	endfunction

	always_comb begin
		logic [2:0] ff_cur;
		logic m_cur;
		logic h_cur;
		ff_cur = beat_in.sof ? 3'h0 : ff_reg;
		m_cur = beat_in.sof ? 1'b0 : match_reg;
		h_cur = beat_in.sof ? 1'b0 : hit_reg;
		ff_next = ff_reg;
		sel_next = sel_reg;
		rep_next = rep_reg;
		match_next = match_reg;
		hit_next = hit_reg;
		wake_next = 1'b0;
		if (clr_in) begin
			ff_next = 3'h0;
			match_next = 1'b0;
			hit_next = 1'b0;
		end else if (beat_in.valid) begin
			ff_next = ff_cur;
			match_next = m_cur;
			hit_next = h_cur;
			if (m_cur) begin
				if (beat_in.data == addr_byte(station_addr_in, sel_reg)) begin
					if (sel_reg == 3'(`LRWPSC_ADDR_BYTES - 1)) begin
						sel_next = 3'h0;
						if (rep_reg == 4'(`LRWPSC_WAKE_ADDR_REPS - 1)) begin
							hit_next = 1'b1;
							match_next = 1'b0;
							ff_next = 3'h0;
						end else begin
							rep_next = rep_reg + 4'h1;
						end
					end else begin
						sel_next = sel_reg + 3'h1;
					end
				end else begin
					// Broken run; a 0xFF may start the next sync
					match_next = 1'b0;
					ff_next = (beat_in.data == 8'hFF) ? 3'h1 : 3'h0;
				end
			end else if (beat_in.data == 8'hFF) begin
				if (ff_cur != 3'(`LRWPSC_WAKE_SYNC_LEN))
					ff_next = ff_cur + 3'h1;
			end else if (ff_cur == 3'(`LRWPSC_WAKE_SYNC_LEN) &&
				beat_in.data == addr_byte(station_addr_in, 3'h0)) begin
				match_next = 1'b1;
				sel_next = 3'h1;
				rep_next = 4'h0;
				ff_next = 3'h0;
			end else begin
				ff_next = 3'h0;
			end
			if (beat_in.eof) begin
				wake_next = enable_in & hit_next & beat_in.addr_ok & beat_in.fcs_ok;
				hit_next = 1'b0;
				match_next = 1'b0;
				ff_next = 3'h0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ff_reg <= 3'h0;
			sel_reg <= 3'h0;
			rep_reg <= 4'h0;
			match_reg <= 1'b0;
			hit_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			ff_reg <= ff_next;
			sel_reg <= sel_next;
			rep_reg <= rep_next;
			match_reg <= match_next;
			hit_reg <= hit_next;
			wake_reg <= wake_next;
		end
	end

	assign wake_out = wake_reg;
endmodule // lrwpsc_wake_detect
`default_nettype wire

/* src/lrwpsc_top.sv */
// Purpose: Software resets, transceiver reset, wake detection, PME and
//          power-state access gating behind a classic Wishbone slave.
// Assumes: All inputs other than nrst_in come from logic on clk_sys_in.
// Notes:   Config space answers in every state; the rest only in D0.
//
// The register addresses and register access over Wishbone were left to the implementer.
`default_nettype none
`include "lrwpsc_map.svh"
module lrwpsc_top import lrwpsc_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADDR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic wb_err_out,
	input wire lrwpsc_rx_beat_t rx_beat_in,
	input wire logic [47:0] station_addr_in,
	input wire logic eeprom_load_in,
	input wire logic eeprom_wol_in,
	output logic pme_n_out,
	output logic pme_oe_n_out,
	output logic irq_out,
	output logic chip_soft_rst_out,
	output logic xcvr_rst_out,
	output logic mac_rx_en_out,
	output logic mac_tx_en_out,
	output logic bus_master_en_out,
	output lrwpsc_pm_state_t pm_state_out
);
	localparam logic [7:0] XCVR_RST_CYC = 8'(`LRWPSC_XCVR_RST_CYC);

	// Bus group
	logic ack_reg, ack_next;
	logic err_reg, err_next;
	logic [31:0] dat_reg, dat_next;

	// Control group
	logic chip_rst_reg, chip_rst_next;
	logic [15:0] rcw_hi_reg, rcw_hi_next;
	logic pme_stat_reg, pme_stat_next;
	logic [14:0] xcvr_ctrl_reg, xcvr_ctrl_next;
	logic [7:0] xcvr_cnt_reg, xcvr_cnt_next;
	logic xcvr_busy_reg, xcvr_busy_next;
	logic [`LRWPSC_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic [`LRWPSC_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
	lrwpsc_pm_state_t pm_reg, pm_next;

	logic [7:0] adr;
	logic req;
	logic acc_ok;
	logic wr_ok;
	logic [31:0] rd_mux;
	logic wol_en;
	logic wake_allow;
	logic wake_pulse;
	logic wake_evt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			merge[8*i +: 8] = sel[i] ? wd[8*i +: 8] : old[8*i +: 8];
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `LRWPSC_ADR_BMCW) || (a == `LRWPSC_ADR_RCW) ||
			(a == `LRWPSC_ADR_PSW) || (a == `LRWPSC_ADR_XCVR) ||
			(a == `LRWPSC_ADR_IRQ_STAT) || (a == `LRWPSC_ADR_IRQ_MASK) ||
			(a == `LRWPSC_ADR_PMCSR);
	endfunction

	assign adr = 8'(wb_adr_in);
	assign req = wb_cyc_in & wb_stb_in;
	// Outside D0 only config space answers; others get err
	assign acc_ok = is_mapped(adr) &&
		(adr >= `LRWPSC_CFG_BASE || pm_reg == LRWPSC_D0);
	// Writes land on the edge where the master sees ack
	assign wr_ok = req & wb_we_in & ack_reg;
	assign wol_en = rcw_hi_reg[`LRWPSC_BIT_WOL - 16];
	// D2 and D3 receive nothing, not even a wake frame
	assign wake_allow = (pm_reg == LRWPSC_D0) || (pm_reg == LRWPSC_D1);
	assign wake_evt = wake_pulse & wol_en & wake_allow;

	lrwpsc_wake_detect u_wake (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.clr_in(chip_rst_reg),
		.enable_in(wol_en & wake_allow),
		.beat_in(rx_beat_in),
		.station_addr_in(station_addr_in),
		.wake_out(wake_pulse)
	);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (adr)
			`LRWPSC_ADR_BMCW: rd_mux[`LRWPSC_BIT_SWRST] = chip_rst_reg;
			`LRWPSC_ADR_RCW: rd_mux[31:16] = rcw_hi_reg;
			`LRWPSC_ADR_PSW: rd_mux[`LRWPSC_BIT_PME_STAT] = pme_stat_reg;
			`LRWPSC_ADR_XCVR: rd_mux[15:0] = {xcvr_busy_reg, xcvr_ctrl_reg};
			`LRWPSC_ADR_IRQ_STAT: rd_mux[`LRWPSC_IRQ_W-1:0] = irq_stat_reg;
			`LRWPSC_ADR_IRQ_MASK: rd_mux[`LRWPSC_IRQ_W-1:0] = irq_mask_reg;
			`LRWPSC_ADR_PMCSR: rd_mux[1:0] = pm_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		ack_next = 1'b0;
		err_next = 1'b0;
		dat_next = dat_reg;
		if (req && !ack_reg && !err_reg) begin
			ack_next = acc_ok;
			err_next = !acc_ok;
			dat_next = acc_ok ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			err_reg <= err_next;
			dat_reg <= dat_next;
		end
	end

	always_comb begin
		logic [31:0] wm;
		wm = 32'h0000_0000;
		chip_rst_next = 1'b0;
		rcw_hi_next = rcw_hi_reg;
		pme_stat_next = pme_stat_reg;
		xcvr_ctrl_next = xcvr_ctrl_reg;
		xcvr_cnt_next = xcvr_cnt_reg;
		irq_stat_next = irq_stat_reg;
		irq_mask_next = irq_mask_reg;
		pm_next = pm_reg;
		if (chip_rst_reg) begin
			// Whole chip back to defaults, power state included
			rcw_hi_next = `LRWPSC_RCW_HI_RST;
			pme_stat_next = 1'b0;
			xcvr_ctrl_next = `LRWPSC_XCVR_CTRL_RST;
			xcvr_cnt_next = 8'h00;
			irq_stat_next = `LRWPSC_IRQ_RST;
			irq_mask_next = `LRWPSC_IRQ_RST;
			pm_next = LRWPSC_D0;
		end else begin
			if (eeprom_load_in)
				rcw_hi_next[`LRWPSC_BIT_WOL - 16] = eeprom_wol_in;
			if (xcvr_cnt_reg != 8'h00) begin
				xcvr_cnt_next = xcvr_cnt_reg - 8'h01;
				if (xcvr_cnt_reg == 8'h01) begin
					xcvr_ctrl_next = `LRWPSC_XCVR_CTRL_RST;
				end
			end
			if (wr_ok) begin
				wm = merge(rd_mux, wb_dat_in, wb_sel_in);
				unique case (adr)
					`LRWPSC_ADR_BMCW:
						chip_rst_next = wb_sel_in[0] & wb_dat_in[`LRWPSC_BIT_SWRST];
					`LRWPSC_ADR_RCW:
						rcw_hi_next = wm[31:16];
					`LRWPSC_ADR_PSW:
						if (wb_sel_in[1] && wb_dat_in[`LRWPSC_BIT_PME_STAT])
							pme_stat_next = 1'b0;
					`LRWPSC_ADR_XCVR: begin
						// Ignored while a transceiver reset runs
						if (xcvr_cnt_reg == 8'h00) begin
							xcvr_ctrl_next = wm[14:0];
							if (wb_sel_in[1] && wb_dat_in[`LRWPSC_BIT_XCVR_RST]) begin
								xcvr_cnt_next = XCVR_RST_CYC;
								xcvr_ctrl_next = `LRWPSC_XCVR_CTRL_RST;
							end
						end
					end
					`LRWPSC_ADR_IRQ_STAT:
						irq_stat_next = irq_stat_next & ~wm[`LRWPSC_IRQ_W-1:0];
					`LRWPSC_ADR_IRQ_MASK:
						irq_mask_next = wm[`LRWPSC_IRQ_W-1:0];
					`LRWPSC_ADR_PMCSR: begin
						if (wb_sel_in[0]) begin
							pm_next = lrwpsc_pm_state_t'(wb_dat_in[1:0]);
							if (pm_reg == LRWPSC_D3 && pm_next == LRWPSC_D0)
								chip_rst_next = 1'b1;
							if (pm_next != pm_reg)
								irq_stat_next[`LRWPSC_IRQ_PM_CHANGE] = 1'b1;
						end
					end
					default: ;
				endcase
			end
			// Hardware set applied last so it beats a same-cycle clear
			if (xcvr_cnt_reg == 8'h01)
				irq_stat_next[`LRWPSC_IRQ_XCVR_DONE] = 1'b1;
			if (wake_evt) begin
				pme_stat_next = 1'b1;
				irq_stat_next[`LRWPSC_IRQ_WAKE] = 1'b1;
			end
		end
		xcvr_busy_next = (xcvr_cnt_next != 8'h00);
	end

	// Power-on reset lands in D0 with defaults
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			chip_rst_reg <= 1'b0;
			rcw_hi_reg <= `LRWPSC_RCW_HI_RST;
			pme_stat_reg <= 1'b0;
			xcvr_ctrl_reg <= `LRWPSC_XCVR_CTRL_RST;
			xcvr_cnt_reg <= 8'h00;
			xcvr_busy_reg <= 1'b0;
			irq_stat_reg <= `LRWPSC_IRQ_RST;
			irq_mask_reg <= `LRWPSC_IRQ_RST;
			pm_reg <= LRWPSC_D0;
		end else begin
			chip_rst_reg <= chip_rst_next;
			rcw_hi_reg <= rcw_hi_next;
			pme_stat_reg <= pme_stat_next;
			xcvr_ctrl_reg <= xcvr_ctrl_next;
			xcvr_cnt_reg <= xcvr_cnt_next;
			xcvr_busy_reg <= xcvr_busy_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			pm_reg <= pm_next;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_err_out = err_reg;
	assign wb_dat_out = dat_reg;
	// Open drain: data always low, enable low while pulling
	assign pme_n_out = 1'b0;
	assign pme_oe_n_out = ~(pme_stat_reg & wol_en);
	assign irq_out = (|(irq_stat_reg & irq_mask_reg)) & (pm_reg == LRWPSC_D0);
	assign chip_soft_rst_out = chip_rst_reg;
	assign xcvr_rst_out = xcvr_busy_reg;
	assign mac_tx_en_out = (pm_reg == LRWPSC_D0);
	assign bus_master_en_out = (pm_reg == LRWPSC_D0);
	assign mac_rx_en_out = (pm_reg == LRWPSC_D0) ||
		(pm_reg == LRWPSC_D1 && wol_en);
	assign pm_state_out = pm_reg;
endmodule // lrwpsc_top
`default_nettype wire

/* bench/lrwpsc_asserts.sv */
// Purpose: Port assertions for lrwpsc_top.
// Assumes: One clock domain, reset nrst_in.
// Notes: Wake timing after a frame is judged by the bench.
`default_nettype none
`include "lrwpsc_map.svh"
module lrwpsc_asserts import lrwpsc_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic [ADDR_W-1:0] wb_adr_in,
	input wire logic wb_ack_out,
	input wire logic wb_err_out,
	input wire logic eeprom_load_in,
	input wire logic pme_oe_n_out,
	input wire logic irq_out,
	input wire logic chip_soft_rst_out,
	input wire logic xcvr_rst_out,
	input wire logic mac_rx_en_out,
	input wire logic mac_tx_en_out,
	input wire logic bus_master_en_out,
	input wire lrwpsc_pm_state_t pm_state_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	logic d0;
	assign take = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
	assign d0 = pm_state_out == LRWPSC_D0;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	soft_rst_a: assert property (chip_soft_rst_out |=>
		!chip_soft_rst_out && d0 && pme_oe_n_out) else $error("soft reset not clean");
	xcvr_hold_a: assert property ($rose(xcvr_rst_out) |-> ##39 xcvr_rst_out ##1 !xcvr_rst_out)
		else $error("transceiver reset length");
	wake_gate_a: assert property ($fell(pme_oe_n_out) |->
		$past(pm_state_out) inside {LRWPSC_D0, LRWPSC_D1}) else $error("wake in D2 or D3");
	irq_d0_a: assert property (irq_out |-> d0)
		else $error("interrupt outside D0");
	init_d0_a: assert property (bus_master_en_out || mac_tx_en_out |-> d0)
		else $error("initiator enabled outside D0");
	rx_gate_a: assert property (mac_rx_en_out |-> d0 || pm_state_out == LRWPSC_D1)
		else $error("receive enabled in D2 or D3");
	cfg_ack_a: assert property (take && wb_adr_in == `LRWPSC_ADR_PMCSR |=> wb_ack_out)
		else $error("config access refused");
	gate_err_a: assert property (take && wb_adr_in < `LRWPSC_CFG_BASE && !d0 |=> wb_err_out)
		else $error("non-config access answered");
	pme_free_a: assert property ($rose(pme_oe_n_out) |->
		$past(wb_ack_out) || $past(chip_soft_rst_out) || $past(eeprom_load_in))
		else $error("wake request dropped unasked");
	cover property ($fell(pme_oe_n_out) && pm_state_out == LRWPSC_D1);
	cover property ($rose(xcvr_rst_out));
	cover property (wb_err_out && !d0);
endmodule // lrwpsc_asserts
bind lrwpsc_top lrwpsc_asserts #(.ADDR_W(ADDR_W)) u_asserts (.*);
`default_nettype wire

/* bench/lrwpsc_host_model.sv */
// Purpose: Host bridge model issuing classic Wishbone cycles.
// Assumes: One request at a time, go_in held until done_out.
// Notes: Write data toggles while idle so stale data never passes.
`default_nettype none
module lrwpsc_host_model (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic go_in,
	input wire logic [40:0] req_in,
	input wire logic ack_in,
	input wire logic err_in,
	input wire logic [31:0] rdat_in,
	output logic cs_out,
	output logic we_out,
	output logic [7:0] adr_out,
	output logic [3:0] sel_out,
	output logic [31:0] wdat_out,
	output logic done_out,
	output logic er_out,
	output logic [31:0] rd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cs_out <= 1'b0;
			we_out <= 1'b0;
			adr_out <= 8'h00;
			sel_out <= 4'h0;
			wdat_out <= 32'h0;
			done_out <= 1'b0;
			er_out <= 1'b0;
			rd_out <= 32'h0;
		end else begin
			done_out <= 1'b0;
			if (cs_out && (ack_in || err_in)) begin
				cs_out <= 1'b0;
				sel_out <= 4'h0;
				done_out <= 1'b1;
				er_out <= err_in;
				rd_out <= rdat_in;
			end else if (go_in && !cs_out && !done_out) begin
				cs_out <= 1'b1;
				{we_out, adr_out, wdat_out} <= req_in;
				sel_out <= 4'hF;
			end else if (!cs_out) begin
				wdat_out <= ~wdat_out;
			end
		end
	end
endmodule // lrwpsc_host_model
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for lrwpsc_top.
// Assumes: Host side is lrwpsc_host_model; frames are driven here.
// Notes: Station address and register data are random from a fixed seed.
`default_nettype none
`include "lrwpsc_map.svh"
module testbench import lrwpsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic go = 1'b0;
	logic ld = 1'b0;
	logic wol = 1'b0;
	logic [40:0] req = '0;
	lrwpsc_rx_beat_t rx = '0;
	logic [47:0] sa = '0;
	logic cs, we, ack, err, done, er, pme_n, pme_oe_n, irq, srst, xrst, rx_en, tx_en, bm_en;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rdv, r;
	lrwpsc_pm_state_t ps, ps_exp;
	logic wol_en;
	int n_mismatch = 0;
	int checked = 0;
	int n_srst = 0;
	int k;
	always #12.5 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in) if (srst === 1'b1) n_srst++;
	lrwpsc_host_model u_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .go_in(go),
		.req_in(req), .ack_in(ack), .err_in(err), .rdat_in(rdat), .cs_out(cs), .we_out(we),
		.adr_out(adr), .sel_out(sel), .wdat_out(wdat), .done_out(done), .er_out(er), .rd_out(rdv));
	lrwpsc_top #(.ADDR_W(8)) u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wb_cyc_in(cs),
		.wb_stb_in(cs), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err), .rx_beat_in(rx),
		.station_addr_in(sa), .eeprom_load_in(ld), .eeprom_wol_in(wol), .pme_n_out(pme_n),
		.pme_oe_n_out(pme_oe_n), .irq_out(irq), .chip_soft_rst_out(srst), .xcvr_rst_out(xrst),
		.mac_rx_en_out(rx_en), .mac_tx_en_out(tx_en), .bus_master_en_out(bm_en),
		.pm_state_out(ps));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s: %h not %h", $time, m, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("Checked %0d, mismatches %0d", checked, n_mismatch);
		if (checked > 0 && n_mismatch == 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic x);
		int n = 0;
		@(posedge clk_sys_in);
		req <= {w, a, d};
		go <= 1'b1;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (done !== 1'b1 && n < 50);
		if (done !== 1'b1) begin
			chk(32'h0, 32'h1, "bus timeout");
			conclude();
		end
		@(posedge clk_sys_in);
		go <= 1'b0;
		chk(er, x, "response");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic x);
		acc(1'b0, a, 32'h0, x);
		chk(rdv, e, "read data");
	endtask
	task automatic look(input logic ei, input logic ep, input string m);
		@(negedge clk_sys_in);
		chk(irq, ei, m);
		chk(pme_oe_n, ep, m);
	endtask
	function automatic logic wexp(input int k, input logic en, input lrwpsc_pm_state_t s);
		return (k == 0 || k == 5) && en && (s == LRWPSC_D0 || s == LRWPSC_D1);
	endfunction
	// Kinds: 0 good, 1 five sync bytes, 2 bad check, 3 filtered, 4 short, 5 two patterns
	task automatic frame(input int k);
		logic [7:0] q[$];
		logic w;
		int i;
		int j;
		w = wexp(k, wol_en, ps_exp);
		q = {8'h00};
		for (j = 0; j <= int'(k == 5); j++) begin
			for (i = 0; i < 6 - int'(k == 1); i++) q.push_back(8'hFF);
			for (i = 0; i < 96 - int'(k == 4); i++) q.push_back(sa[47 - 8 * (i % 6) -: 8]);
			q.push_back(8'h00);
		end
		foreach (q[b]) begin
			@(posedge clk_sys_in);
			rx <= '{1'b1, b == 0, b == q.size() - 1, k != 3, k != 2, q[b]};
		end
		@(posedge clk_sys_in);
		rx <= lrwpsc_rx_beat_t'({5'b0, 8'($urandom)});
		// Flag lands two edges after the end-of-frame edge
		@(negedge clk_sys_in);
		chk(pme_oe_n, 1'b1, "wake too early");
		look(w && ps_exp == LRWPSC_D0, !w, "wake");
	endtask
	initial begin
		void'($urandom(32'hA37AFEF9));
		sa <= {8'h02, $urandom, 8'($urandom)};
		r = $urandom;
		repeat (4) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rd(`LRWPSC_ADR_RCW, 32'h0, 1'b0);
		rd(`LRWPSC_ADR_PMCSR, 32'h0, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		chk(pme_n, 1'b0, "wake pin data");
		acc(1'b1, `LRWPSC_ADR_RCW, {r[31:16], 16'h0}, 1'b0);
		rd(`LRWPSC_ADR_RCW, {r[31:16], 16'h0}, 1'b0);
		acc(1'b1, `LRWPSC_ADR_BMCW, 32'h1, 1'b0);
		rd(`LRWPSC_ADR_BMCW, 32'h0, 1'b0);
		rd(`LRWPSC_ADR_RCW, 32'h0, 1'b0);
		chk(n_srst, 32'h1, "soft reset pulse");
		acc(1'b1, `LRWPSC_ADR_XCVR, {16'h0, 1'b1, r[14:0]}, 1'b0);
		@(negedge clk_sys_in);
		chk(xrst, 1'b1, "transceiver reset");
		acc(1'b1, `LRWPSC_ADR_XCVR, 32'h7FFF, 1'b0);
		repeat (40) @(posedge clk_sys_in);
		rd(`LRWPSC_ADR_XCVR, 32'h0, 1'b0);
		rd(`LRWPSC_ADR_IRQ_STAT, 32'h2, 1'b0);
		acc(1'b1, `LRWPSC_ADR_IRQ_STAT, 32'h7, 1'b0);
		$display("Test resets done");
		@(posedge clk_sys_in);
		wol <= 1'b1;
		ld <= 1'b1;
		@(posedge clk_sys_in);
		ld <= 1'b0;
		wol_en = 1'b1;
		ps_exp = LRWPSC_D0;
		rd(`LRWPSC_ADR_RCW, 32'h0004_0000, 1'b0);
		acc(1'b1, `LRWPSC_ADR_IRQ_MASK, 32'h1, 1'b0);
		for (k = 0; k < 6; k++) begin
			frame(k);
			rd(`LRWPSC_ADR_PSW, wexp(k, 1'b1, LRWPSC_D0) ? 32'h8000 : 32'h0, 1'b0);
			acc(1'b1, `LRWPSC_ADR_PSW, 32'h8000, 1'b0);
			acc(1'b1, `LRWPSC_ADR_IRQ_STAT, 32'h1, 1'b0);
			look(1'b0, 1'b1, "wake released");
		end
		frame(0);
		acc(1'b1, `LRWPSC_ADR_IRQ_MASK, 32'h0, 1'b0);
		look(1'b0, 1'b0, "masked");
		acc(1'b1, `LRWPSC_ADR_IRQ_MASK, 32'h1, 1'b0);
		look(1'b1, 1'b0, "unmasked");
		acc(1'b1, `LRWPSC_ADR_RCW, 32'h0, 1'b0);
		look(1'b1, 1'b1, "wake disabled");
		acc(1'b1, `LRWPSC_ADR_IRQ_STAT, 32'h1, 1'b0);
		acc(1'b1, `LRWPSC_ADR_RCW, 32'h0004_0000, 1'b0);
		look(1'b0, 1'b0, "wake enabled again");
		acc(1'b1, `LRWPSC_ADR_PSW, 32'h8000, 1'b0);
		$display("Test wake frames done");
		for (k = 1; k < 4; k++) begin
			ps_exp = lrwpsc_pm_state_t'(k);
			acc(1'b1, `LRWPSC_ADR_PMCSR, 32'(k), 1'b0);
			rd(`LRWPSC_ADR_PMCSR, 32'(k), 1'b0);
			rd(`LRWPSC_ADR_RCW, 32'h0, 1'b1);
			chk(rx_en, k == 1, "receive enable");
			chk({tx_en, bm_en, ps}, {2'b00, 2'(k)}, "initiators off");
			frame(0);
			ps_exp = LRWPSC_D0;
			acc(1'b1, `LRWPSC_ADR_PMCSR, 32'h0, 1'b0);
			rd(`LRWPSC_ADR_RCW, k == 3 ? 32'h0 : 32'h0004_0000, 1'b0);
			chk({tx_en, bm_en, ps}, 32'hC, "initiators back");
			acc(1'b1, `LRWPSC_ADR_PSW, 32'h8000, 1'b0);
			acc(1'b1, `LRWPSC_ADR_IRQ_STAT, 32'h7, 1'b0);
		end
		chk(n_srst, 32'h2, "power-up reset");
		acc(1'b1, `LRWPSC_ADR_RCW, 32'h0004_0000, 1'b0);
		$display("Test power states done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
